//--- core/cwg_top.sv
// Complementary waveform generator with dead band, shutdown and AXI4-Lite registers
//
// What this block does
// - Start by setting auto-restart or by clearing the shutdown status bit.
// - In shutdown outputs follow override levels; polarity not applied to forced levels.
// - Output B override field bits 7-6: 11 high, 10 low, 01 tri, 00 inactive.
// - Output A override field bits 5-4: 11 high, 10 low, 01 tri, 00 inactive.
// - Without auto-restart, shutdown holds until cleared; resume on next input rising edge.
// - Software clear of shutdown status only succeeds if enabled shutdown inputs inactive.
// - With auto-restart, hardware clears status when condition ends; resume on rising edge.
// - Control zero bit 7 enables module; disabled makes enables and levels ineffective.
// - Control zero bits 6 and 5 connect outputs B and A to pins.
// - Control zero bits 4 and 3 invert outputs B and A when set.
// - Control zero bit 0 selects dead-band clock; bits 2-1 read zero.
// - Control one bits 1-0 select input source: logic cell, oscillator, PWM2, PWM1.
// - Status bit 7 of control two set by hardware on shutdown, forces outputs to their override levels.
// - Control two bit 6 auto-restart, bit 1 logic-cell shutdown, bit 0 fault shutdown.
// - Rising dead-band count n gives n to n+1 counts; zero gives none.
// - Falling dead-band count same meaning; zero bypasses dead band.
// - On rising input edge, B off at once, count rising dead band, then A on.
// - On falling input edge, A off at once, count falling dead band, then B on.
// - Shutdown inputs act on level; status cannot clear while enabled input active.
// - Right after enabling, both drive outputs are held cleared.
`timescale 1ns/1ps

module cwg_top
#(
  parameter int DBW = 6
)
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        FAST_OSC_TICK,
  input  wire logic        FIRST_PWM_OUTPUT,
  input  wire logic        SECOND_PWM_OUTPUT,
  input  wire logic        OSCILLATOR_OUTPUT,
  input  wire logic        LOGIC_CELL_OUTPUT,
  input  wire logic        FAULT_INPUT_LOW_N,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             OUTPUT_A_O,
  output logic             OUTPUT_A_OE,
  output logic             OUTPUT_B_O,
  output logic             OUTPUT_B_OE,
  output logic             SHUTDOWN_ACTIVE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0]      ctrl0;
    logic [7:0]      ctrl1;
    logic [7:0]      ctrl2;
    logic [DBW-1:0]  dbr;
    logic [DBW-1:0]  dbf;
    logic [1:0]      in_sync;
    logic [1:0]      lc_sync;
    logic [1:0]      flt_sync;
    logic            in_prev;
    logic            run;
    logic            en_prev;
    cwg_pkg::cwg_db_t db_state;
    logic [DBW-1:0]  db_cnt;
    logic            drv_a;
    logic            drv_b;
    logic            aw_got;
    logic [7:0]      aw_addr;
    logic            w_got;
    logic [7:0]      w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic            bad_w;
    logic            rvalid;
    logic [7:0]      rdata;
    logic            bad_r;
  } cwg_state_t;

  cwg_state_t st_r;
  cwg_state_t st_nxt;

  logic       src_raw;
  logic       sd_cond;
  logic       in_rise;
  logic       in_fall;
  logic       db_tick;
  logic       wr_fire;
  logic       wr_hit_ctrl2;
  logic       sw_status;
  logic       sw_clear_req;
  logic [7:0] rd_val;

  // ----------------------------------------------------------------
  // Input selection and edge detection
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (st_r.ctrl1[cwg_pkg::LSB_IS +: 2])
      cwg_pkg::SRC_PWM1: src_raw = FIRST_PWM_OUTPUT;
      cwg_pkg::SRC_PWM2: src_raw = SECOND_PWM_OUTPUT;
      cwg_pkg::SRC_OSC:  src_raw = OSCILLATOR_OUTPUT;
      cwg_pkg::SRC_LC:   src_raw = LOGIC_CELL_OUTPUT;
    endcase
  end

  // Only the second stage is looked at; the first may be metastable
  assign in_rise = st_r.in_sync[1] & ~st_r.in_prev;
  assign in_fall = ~st_r.in_sync[1] & st_r.in_prev;
  // Level sensitive: condition holds as long as any enabled input is active
  assign sd_cond = (st_r.ctrl2[cwg_pkg::BIT_LCSD] & st_r.lc_sync[1])
                 | (st_r.ctrl2[cwg_pkg::BIT_FLTSD] & ~st_r.flt_sync[1]);
  // Fast oscillator arrives as a tick enable so the design keeps one clock
  assign db_tick = st_r.ctrl0[cwg_pkg::BIT_CS] ? FAST_OSC_TICK : 1'b1;

  // ----------------------------------------------------------------
  // Bus write and read decode
  // ----------------------------------------------------------------
  assign wr_fire      = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign wr_hit_ctrl2 = wr_fire & (st_r.aw_addr[7:2] == {4'h0, cwg_pkg::ADDR_CTRL2[3:2]})
                      & st_r.w_strb[0];
  assign sw_status    = st_r.w_data[cwg_pkg::BIT_STAT];
  assign sw_clear_req = wr_hit_ctrl2 & ~sw_status;

  always_comb
  begin
    unique case (ARADDR[7:2])
      6'h00: rd_val = st_r.ctrl0 & cwg_pkg::MASK_CTRL0;
      6'h01: rd_val = st_r.ctrl1 & cwg_pkg::MASK_CTRL1;
      6'h02: rd_val = st_r.ctrl2 & cwg_pkg::MASK_CTRL2;
      6'h03: rd_val = 8'(st_r.dbr);
      6'h04: rd_val = 8'(st_r.dbf);
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.in_sync  = {st_r.in_sync[0], src_raw};
    st_nxt.lc_sync  = {st_r.lc_sync[0], LOGIC_CELL_OUTPUT};
    st_nxt.flt_sync = {st_r.flt_sync[0], FAULT_INPUT_LOW_N};
    st_nxt.in_prev  = st_r.in_sync[1];
    st_nxt.en_prev  = st_r.ctrl0[cwg_pkg::BIT_EN];

    // Bus channels
    if (AWVALID && !st_r.aw_got)
    begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = AWADDR;
    end
    if (WVALID && !st_r.w_got)
    begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = WDATA[7:0];
      st_nxt.w_strb = WSTRB;
    end
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bad_w  = (st_r.aw_addr[7:2] > 6'h04);
      if (st_r.w_strb[0])
      begin
        unique case (st_r.aw_addr[7:2])
          6'h00: st_nxt.ctrl0 = st_r.w_data & cwg_pkg::MASK_CTRL0;
          6'h01: st_nxt.ctrl1 = st_r.w_data & cwg_pkg::MASK_CTRL1;
          6'h02: st_nxt.ctrl2 = st_r.w_data & cwg_pkg::MASK_CTRL2;
          6'h03: st_nxt.dbr   = st_r.w_data[DBW-1:0];
          6'h04: st_nxt.dbf   = st_r.w_data[DBW-1:0];
          default: st_nxt.ctrl0 = st_r.ctrl0;
        endcase
      end
    end
    if (st_r.bvalid && BREADY)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (ARVALID && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.bad_r  = (ARADDR[7:2] > 6'h04);
    end
    else if (st_r.rvalid && RREADY)
    begin
      st_nxt.rvalid = 1'b0;
    end

    // Shutdown status: hardware set wins over software clear
    if (sw_clear_req && sd_cond)
    begin
      st_nxt.ctrl2[cwg_pkg::BIT_STAT] = 1'b1;
    end
    if (sd_cond)
    begin
      st_nxt.ctrl2[cwg_pkg::BIT_STAT] = 1'b1;
    end
    else if (st_r.ctrl2[cwg_pkg::BIT_ARS] && st_r.ctrl2[cwg_pkg::BIT_STAT] && !wr_hit_ctrl2)
    begin
      st_nxt.ctrl2[cwg_pkg::BIT_STAT] = 1'b0;
    end

    // Output waveform
    if (!st_r.ctrl0[cwg_pkg::BIT_EN] || (st_r.ctrl0[cwg_pkg::BIT_EN] && !st_r.en_prev))
    begin
      st_nxt.drv_a    = 1'b0;
      st_nxt.drv_b    = 1'b0;
      st_nxt.run      = 1'b0;
      st_nxt.db_state = cwg_pkg::DB_IDLE;
    end
    else if (st_r.ctrl2[cwg_pkg::BIT_STAT])
    begin
      // Outputs go inactive; restart waits for the next rising edge
      st_nxt.run      = 1'b0;
      st_nxt.drv_a    = 1'b0;
      st_nxt.drv_b    = 1'b0;
      st_nxt.db_state = cwg_pkg::DB_IDLE;
    end
    else if (!st_r.run)
    begin
      if (in_rise)
      begin
        st_nxt.run = 1'b1;
      end
    end
    if (st_r.ctrl0[cwg_pkg::BIT_EN] && st_r.en_prev && !st_r.ctrl2[cwg_pkg::BIT_STAT]
        && (st_r.run || in_rise))
    begin
      if (in_rise)
      begin
        st_nxt.drv_b  = 1'b0;
        st_nxt.db_cnt = '0;
        if (st_r.dbr == '0)
        begin
          st_nxt.drv_a    = 1'b1;
          st_nxt.db_state = cwg_pkg::DB_IDLE;
        end
        else
        begin
          st_nxt.db_state = cwg_pkg::DB_RISE;
        end
      end
      else if (in_fall)
      begin
        st_nxt.drv_a  = 1'b0;
        st_nxt.db_cnt = '0;
        if (st_r.dbf == '0)
        begin
          st_nxt.drv_b    = 1'b1;
          st_nxt.db_state = cwg_pkg::DB_IDLE;
        end
        else
        begin
          st_nxt.db_state = cwg_pkg::DB_FALL;
        end
      end
      else if (db_tick)
      begin
        unique case (st_r.db_state)
          cwg_pkg::DB_IDLE: st_nxt.db_cnt = st_r.db_cnt;
          cwg_pkg::DB_RISE:
          begin
            st_nxt.db_cnt = st_r.db_cnt + 1'b1;
            if (st_r.db_cnt + 1'b1 == st_r.dbr)
            begin
              st_nxt.drv_a    = 1'b1;
              st_nxt.db_state = cwg_pkg::DB_IDLE;
            end
          end
          cwg_pkg::DB_FALL:
          begin
            st_nxt.db_cnt = st_r.db_cnt + 1'b1;
            if (st_r.db_cnt + 1'b1 == st_r.dbf)
            begin
              st_nxt.drv_b    = 1'b1;
              st_nxt.db_state = cwg_pkg::DB_IDLE;
            end
          end
          default: st_nxt.db_state = cwg_pkg::DB_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  function automatic logic [1:0] pin_drive(input logic [1:0] lvl, input logic sd,
                                           input logic drv, input logic pol);
    logic [1:0] r;
    r = {1'b1, drv ^ pol};
    if (sd)
    begin
      unique case (lvl)
        cwg_pkg::LVL_HIGH:  r = 2'b11;
        cwg_pkg::LVL_LOW:   r = 2'b10;
        cwg_pkg::LVL_TRI:   r = 2'b00;
        cwg_pkg::LVL_INACT: r = {1'b1, pol};
      endcase
    end
    return r;
  endfunction

  logic [1:0] pa;
  logic [1:0] pb;
  logic       sd_now;
  assign sd_now = st_r.ctrl2[cwg_pkg::BIT_STAT];
  assign pa = pin_drive(st_r.ctrl1[cwg_pkg::LSB_LVLA +: 2], sd_now, st_r.drv_a,
                        st_r.ctrl0[cwg_pkg::BIT_POLA]);
  assign pb = pin_drive(st_r.ctrl1[cwg_pkg::LSB_LVLB +: 2], sd_now, st_r.drv_b,
                        st_r.ctrl0[cwg_pkg::BIT_POLB]);
  // Module enable gates the pin enables as a whole
  assign OUTPUT_A_OE = st_r.ctrl0[cwg_pkg::BIT_EN] & st_r.ctrl0[cwg_pkg::BIT_OEA] & pa[1];
  assign OUTPUT_B_OE = st_r.ctrl0[cwg_pkg::BIT_EN] & st_r.ctrl0[cwg_pkg::BIT_OEB] & pb[1];
  assign OUTPUT_A_O  = pa[0];
  assign OUTPUT_B_O  = pb[0];
  assign SHUTDOWN_ACTIVE = sd_now;

  assign AWREADY = ~st_r.aw_got;
  assign WREADY  = ~st_r.w_got;
  assign BVALID  = st_r.bvalid;
  assign BRESP   = st_r.bad_w ? cwg_pkg::RESP_SLVERR : cwg_pkg::RESP_OK;
  assign ARREADY = ~st_r.rvalid;
  assign RVALID  = st_r.rvalid;
  assign RDATA   = {24'h000000, st_r.rdata};
  assign RRESP   = st_r.bad_r ? cwg_pkg::RESP_SLVERR : cwg_pkg::RESP_OK;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SD_SETS: assert property (@(posedge CLK) disable iff (!NRST)
    sd_cond |=> st_r.ctrl2[cwg_pkg::BIT_STAT])
    else $error("Shutdown condition did not set status");
  AST_NO_CLEAR: assert property (@(posedge CLK) disable iff (!NRST)
    (sw_clear_req && sd_cond) |=> st_r.ctrl2[cwg_pkg::BIT_STAT])
    else $error("Status cleared while shutdown input active");
  AST_AUTO: assert property (@(posedge CLK) disable iff (!NRST)
    (!sd_cond && st_r.ctrl2[cwg_pkg::BIT_ARS] && sd_now && !wr_hit_ctrl2)
    |=> !st_r.ctrl2[cwg_pkg::BIT_STAT])
    else $error("Auto-restart did not clear status");
  AST_RISE_B_OFF: assert property (@(posedge CLK) disable iff (!NRST)
    (in_rise && st_r.run && !sd_now && st_r.en_prev && st_r.ctrl0[cwg_pkg::BIT_EN])
    |=> !st_r.drv_b)
    else $error("Output B not turned off on rising edge");
  AST_FALL_A_OFF: assert property (@(posedge CLK) disable iff (!NRST)
    (in_fall && st_r.run && !sd_now && st_r.en_prev && st_r.ctrl0[cwg_pkg::BIT_EN])
    |=> !st_r.drv_a)
    else $error("Output A not turned off on falling edge");
  AST_NO_OVERLAP: assert property (@(posedge CLK) disable iff (!NRST)
    !(st_r.drv_a && st_r.drv_b))
    else $error("Both drives active");
  AST_DISABLED: assert property (@(posedge CLK) disable iff (!NRST)
    !st_r.ctrl0[cwg_pkg::BIT_EN] |-> (!OUTPUT_A_OE && !OUTPUT_B_OE))
    else $error("Pin driven while module disabled");
  AST_ENABLE_CLR: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(st_r.ctrl0[cwg_pkg::BIT_EN]) |=> (!st_r.drv_a && !st_r.drv_b))
    else $error("Drives not cleared after enable");
  AST_FORCE_HIGH: assert property (@(posedge CLK) disable iff (!NRST)
    (sd_now && st_r.ctrl1[cwg_pkg::LSB_LVLA +: 2] == cwg_pkg::LVL_HIGH) |-> OUTPUT_A_O)
    else $error("Override high not applied to output A");

endmodule

//--- common/cwg_pkg.sv
// Package of register map, field positions and encodings for the waveform generator
package cwg_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h4;
  localparam logic [3:0] ADDR_CTRL2 = 4'h8;
  localparam logic [3:0] ADDR_DBR   = 4'hc;
  localparam logic [4:0] ADDR_DBF_W = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_EN     = 7;
  localparam int BIT_OEB    = 6;
  localparam int BIT_OEA    = 5;
  localparam int BIT_POLB   = 4;
  localparam int BIT_POLA   = 3;
  localparam int BIT_CS     = 0;
  localparam int LSB_LVLB   = 6;
  localparam int LSB_LVLA   = 4;
  localparam int LSB_IS     = 0;
  localparam int BIT_STAT   = 7;
  localparam int BIT_ARS    = 6;
  localparam int BIT_LCSD   = 1;
  localparam int BIT_FLTSD  = 0;
  localparam int DB_W       = 6;

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_CTRL0  = 8'hf9;
  localparam logic [7:0] MASK_CTRL1  = 8'hf3;
  localparam logic [7:0] MASK_CTRL2  = 8'hc3;
  localparam logic [7:0] MASK_DB     = 8'h3f;
  localparam logic [7:0] RST_REG     = 8'h00;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_HIGH  = 2'h3;
  localparam logic [1:0] LVL_LOW   = 2'h2;
  localparam logic [1:0] LVL_TRI   = 2'h1;
  localparam logic [1:0] LVL_INACT = 2'h0;
  localparam logic [1:0] SRC_PWM1  = 2'h0;
  localparam logic [1:0] SRC_PWM2  = 2'h1;
  localparam logic [1:0] SRC_OSC   = 2'h2;
  localparam logic [1:0] SRC_LC    = 2'h3;
  localparam logic [1:0] RESP_OK     = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    DB_IDLE = 2'b00,
    DB_RISE = 2'b01,
    DB_FALL = 2'b10
  } cwg_db_t;

endpackage

//--- test/cwg_switch_model.sv
// Model of the gate drivers that hang on the two generator outputs
`timescale 1ns/1ps

module cwg_switch_model
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic a_o,
  input  wire logic a_oe,
  input  wire logic b_o,
  input  wire logic b_oe,
  input  wire logic shut,
  output logic      gate_a,
  output logic      gate_b,
  output int        overlap
);
  // ----------------------------------------------------------------
  // Gate levels
  // ----------------------------------------------------------------
  // Gate inputs carry pull-downs, so a released pin turns its switch off
  assign gate_a = a_oe ? a_o : 1'b0;
  assign gate_b = b_oe ? b_o : 1'b0;
  // Both switches on outside shutdown would short the supply rail
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      overlap <= 0;
    else if (gate_a && gate_b && !shut)
      overlap <= overlap + 1;
  end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the complementary waveform generator
`timescale 1ns/1ps

module tb_top;
  localparam logic [7:0] A_C0 = {4'h0, cwg_pkg::ADDR_CTRL0};
  localparam logic [7:0] A_C1 = {4'h0, cwg_pkg::ADDR_CTRL1};
  localparam logic [7:0] A_C2 = {4'h0, cwg_pkg::ADDR_CTRL2};
  localparam logic [7:0] A_DR = {4'h0, cwg_pkg::ADDR_DBR};
  localparam logic [7:0] A_DF = {3'h0, cwg_pkg::ADDR_DBF_W};
  localparam logic [1:0] OK   = cwg_pkg::RESP_OK;
  localparam logic [7:0] MSK [5] = '{cwg_pkg::MASK_CTRL0, cwg_pkg::MASK_CTRL1,
                                     cwg_pkg::MASK_CTRL2, cwg_pkg::MASK_DB, cwg_pkg::MASK_DB};
  logic        CLK, NRST, FAULT_INPUT_LOW_N, sv, lc_lvl, gate_a, gate_b;
  logic        AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID, ARREADY;
  logic        RVALID, OUTPUT_A_O, OUTPUT_A_OE, OUTPUT_B_O, OUTPUT_B_OE, SHUTDOWN_ACTIVE;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [31:0] seed = 32'h5f;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, sel;
  logic [1:0]  tick_cnt = 2'h0;
  logic [2:0]  noise = 3'h0;
  int          fail_count, check_count, overlap;

  cwg_top u_dut
  (
    .CLK, .NRST, .FAST_OSC_TICK(tick_cnt == 2'h0),
    .FIRST_PWM_OUTPUT(sel == 2'h0 ? sv : noise[0]), .SECOND_PWM_OUTPUT(sel == 2'h1 ? sv : noise[1]),
    .OSCILLATOR_OUTPUT(sel == 2'h2 ? sv : noise[2]), .LOGIC_CELL_OUTPUT(sel == 2'h3 ? sv : lc_lvl),
    .FAULT_INPUT_LOW_N, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
    .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
    .OUTPUT_A_O, .OUTPUT_A_OE, .OUTPUT_B_O, .OUTPUT_B_OE, .SHUTDOWN_ACTIVE
  );
  cwg_switch_model u_sw
  (
    .clk(CLK), .nrst(NRST), .a_o(OUTPUT_A_O), .a_oe(OUTPUT_A_OE), .b_o(OUTPUT_B_O),
    .b_oe(OUTPUT_B_OE), .shut(SHUTDOWN_ACTIVE), .gate_a, .gate_b, .overlap
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected {enable, level} of a pin held by its shutdown override
  function automatic logic [31:0] ovr(input logic [1:0] c, input logic oe, input logic pol);
    logic v;
    v = (c == 2'h0) ? pol : c[0];
    return {30'h0, oe && c != 2'h1, oe && c != 2'h1 && v};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int n, input int lo, input int hi);
    check_count++;
    if (n < lo || n > hi)
    begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h..%h", $time, n, lo, hi);
    end
  endtask
  // Handshakes are sampled at the falling edge, where they stand for the next rising edge
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int         n;
    logic       aw_ok;
    logic       w_ok;
    logic       b_ok;
    logic [1:0] resp;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    n = 0;
    b_ok = 1'b0;
    while (!b_ok && n < 40)
    begin
      @(negedge CLK);
      aw_ok = AWVALID & AWREADY;
      w_ok = WVALID & WREADY;
      b_ok = BVALID;
      resp = BRESP;
      @(posedge CLK);
      n++;
      if (aw_ok)
        AWVALID <= 1'b0;
      if (w_ok)
        WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
    if (!b_ok)
    begin
      fail_count++;
      give_verdict();
    end
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar_ok;
    logic r_ok;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    n = 0;
    r_ok = 1'b0;
    while (!r_ok && n < 40)
    begin
      @(negedge CLK);
      ar_ok = ARVALID & ARREADY;
      r_ok = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
      n++;
      if (ar_ok)
        ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
    if (!r_ok)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(d, {24'h0, e});
  endtask
  // Falling edges until output A (0), output B (1) or shutdown (2) reaches v
  // Called at a falling edge so that outputs are settled when looked at
  task automatic until_sig(input int k, input logic v, output int n);
    n = 0;
    while (n < 300 && (k == 0 ? OUTPUT_A_O : k == 1 ? OUTPUT_B_O : SHUTDOWN_ACTIVE) !== v)
    begin
      @(negedge CLK);
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  // One input period; k is system cycles per dead-band count, sync adds a few
  task automatic dband(input logic [5:0] r, input logic [5:0] f, input int k);
    int n;
    int t;
    axw(A_DR, {2'h0, r}, OK);
    axw(A_DF, {2'h0, f}, OK);
    sv <= 1'b1;
    @(negedge CLK);
    until_sig(1, 1'b0, t);
    rng(t, 0, 4);
    until_sig(0, 1'b1, n);
    rng(t + n, k * r, k * r + k + 4);
    @(posedge CLK);
    sv <= 1'b0;
    @(negedge CLK);
    until_sig(0, 1'b0, t);
    rng(t, 1, 4);
    until_sig(1, 1'b1, n);
    rng(t + n, k * f, k * f + k + 4);
    @(posedge CLK);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Unselected PWM and oscillator sources toggle at random so a wrong select shows up as edges
  always @(posedge CLK)
  begin
    noise <= 3'(rnd());
    tick_cnt <= tick_cnt + 2'h1;
  end
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial
  begin
    repeat (60000) @(posedge CLK);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    int          i;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, sv, lc_lvl, NRST} = '0;
    {AWADDR, ARADDR, WDATA, sel} = '0;
    WSTRB = 4'hf;
    FAULT_INPUT_LOW_N = 1'b1;
    fail_count = 0;
    check_count = 0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    for (i = 0; i < 5; i++)
      rchk(8'(i * 4), 8'h00);
    // Shutdown is set before the enable so the overlap count skips both pins forced high
    for (i = 4; i >= 0; i--)
    begin
      d = (i == 2) ? 32'hbf : 32'hff;
      axw(8'(i * 4), d[7:0], OK);
      rchk(8'(i * 4), d[7:0] & MSK[i]);
    end
    axw(8'h14, 8'h55, cwg_pkg::RESP_SLVERR);
    axr(8'h14, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, cwg_pkg::RESP_SLVERR});
    axw(A_C0, 8'h60, OK);
    chk({30'h0, OUTPUT_A_OE, OUTPUT_B_OE}, 32'h0);
    $display("test registers done");
    axw(A_C2, 8'h81, OK);
    for (i = 0; i < 16; i++)
    begin
      d = rnd();
      axw(A_C1, {i[3:0], 4'h0}, OK);
      axw(A_C0, {1'b1, d[1], d[0], d[3], d[2], 3'h0}, OK);
      chk({30'h0, OUTPUT_A_OE, OUTPUT_A_O & OUTPUT_A_OE}, ovr(i[1:0], d[0], d[2]));
      chk({30'h0, OUTPUT_B_OE, OUTPUT_B_O & OUTPUT_B_OE}, ovr(i[3:2], d[1], d[3]));
    end
    $display("test overrides done");
    axw(A_C1, 8'h00, OK);
    axw(A_C0, 8'he0, OK);
    axw(A_C2, 8'h01, OK);
    rchk(A_C2, 8'h01);
    for (i = 0; i < 4; i++)
    begin
      sel <= i[1:0];
      repeat (4) @(posedge CLK);
      axw(A_C1, {6'h0, i[1:0]}, OK);
      repeat (80) @(posedge CLK);
      d = rnd();
      dband(i == 0 ? 6'h00 : d[5:0], i == 3 ? 6'h3f : d[13:8] & 6'h0f, 1);
    end
    sel <= 2'h0;
    repeat (4) @(posedge CLK);
    axw(A_C1, 8'h00, OK);
    repeat (80) @(posedge CLK);
    axw(A_C0, 8'he1, OK);
    dband(6'h05, 6'h03, 4);
    axw(A_C0, 8'he0, OK);
    $display("test dead band done");
    axw(A_C1, 8'hb0, OK);
    FAULT_INPUT_LOW_N <= 1'b0;
    @(negedge CLK);
    until_sig(2, 1'b1, n);
    rng(n, 1, 4);
    chk({30'h0, OUTPUT_A_O, OUTPUT_B_O}, 32'h2);
    axw(A_C2, 8'h01, OK);
    rchk(A_C2, 8'h81);
    FAULT_INPUT_LOW_N <= 1'b1;
    repeat (8) @(posedge CLK);
    chk({31'h0, SHUTDOWN_ACTIVE}, 32'h1);
    axw(A_C2, 8'h01, OK);
    rchk(A_C2, 8'h01);
    repeat (8) @(posedge CLK);
    chk({31'h0, OUTPUT_A_O}, 32'h0);
    dband(6'h02, 6'h02, 1);
    axw(A_C2, 8'h42, OK);
    lc_lvl <= 1'b1;
    @(negedge CLK);
    until_sig(2, 1'b1, n);
    rng(n, 1, 4);
    @(posedge CLK);
    lc_lvl <= 1'b0;
    @(negedge CLK);
    until_sig(2, 1'b0, n);
    rng(n, 1, 6);
    dband(6'h01, 6'h00, 1);
    $display("test shutdown done");
    chk(overlap, 32'h0);
    give_verdict();
  end
endmodule
